// >>> hdl/dma_class_mode_sequencer.sv
// Sequencer of a single-channel byte DMA with AXI4-Lite registers.
// Assumes busack, ready and the data bus pins are asynchronous to aclk.
module dma_class_mode_sequencer
	import dma_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System bus arbitration
	output logic bus_req,
	input wire logic bus_ack,
	// Port ready and interrupt
	input wire logic port_ready,
	output logic int_req,
	// System bus
	output sysbus_t sys_out,
	output logic sys_oe,
	input wire logic [7:0] sys_din,
	output logic sys_data_oe
);

	// ==========================================================
	// Types and signals
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_WAIT_RDY = 4'h1,
		S_REQ = 4'h2,
		S_RD = 4'h3,
		S_WR = 4'h4,
		S_FLY = 4'h5,
		S_CHECK = 4'h6,
		S_PAUSE = 4'h7,
		S_REL = 4'h8
	} state_t;

	state_t state_q, state_d;
	logic [1:0] cyc_q, cyc_d;
	logic [15:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d, count_q, count_d;
	logic [7:0] data_q, data_d;
	logic first_q, first_d, stop_q, stop_d, own_q, own_d;
	sysbus_t bus_q, bus_d;
	logic [1:0] ack_sync_q, rdy_sync_q;
	logic [7:0] din_s1_q, din_s2_q;
	ctrl_t ctrl_q, ctrl_d;
	port_t port_q, port_d;
	logic [15:0] start_a_q, start_a_d, start_b_q, start_b_d, len_q, len_d;
	logic [7:0] match_q, match_d, mask_q, mask_d;
	logic [3:0] status_q, status_d, st_set, st_clr;
	logic hw_stop;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d, wr_word, rd_word;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, wr_err, rd_err, do_wr;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic busack_s, ready_eff, hit, search_on, write_on, fly_ok, cyc_end, eob;
	logic [15:0] eff_len;

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_sync_q <= 2'h0;
			rdy_sync_q <= 2'h0;
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end else begin
			ack_sync_q <= {ack_sync_q[0], bus_ack};
			rdy_sync_q <= {rdy_sync_q[0], port_ready};
			din_s1_q <= sys_din;
			din_s2_q <= din_s1_q;
		end
	end

	assign busack_s = ack_sync_q[1];
	assign ready_eff = ctrl_q.force_ready | (rdy_sync_q[1] == ctrl_q.ready_high);

	// ==========================================================
	// Class decode
	assign search_on = (ctrl_q.op_class == CLS_SEARCH) || (ctrl_q.op_class == CLS_XFER_SEARCH);
	assign write_on = (ctrl_q.op_class != CLS_SEARCH);
	assign fly_ok = ctrl_q.simultaneous && write_on && (port_q.a_is_io != port_q.b_is_io);
	assign cyc_end = (cyc_q == CYC_LAST);
	assign eff_len = (len_q == 16'h0000) ? 16'h0001 : len_q;
	assign eob = (count_q == eff_len);

	dma_match_cmp u_cmp (
		.data(data_q),
		.match(match_q),
		.mask(mask_q),
		.hit(hit)
	);

	function automatic logic [15:0] step_addr(input logic [15:0] a, input step_t s);
		if (s == STEP_INC) begin
			return a + 16'h0001;
		end else if (s == STEP_DEC) begin
			return a - 16'h0001;
		end
		return a;
	endfunction : step_addr

	// ==========================================================
	// Sequencer next state
	always_comb begin
		state_d = state_q;
		cyc_d = cyc_q;
		cnt_a_d = cnt_a_q;
		cnt_b_d = cnt_b_q;
		count_d = count_q;
		data_d = data_q;
		first_d = first_q;
		stop_d = stop_q;
		own_d = own_q;
		st_set = 4'h0;
		hw_stop = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (ctrl_q.enable) begin
					cnt_a_d = start_a_q;
					cnt_b_d = start_b_q;
					count_d = 16'h0000;
					first_d = 1'b1;
					stop_d = 1'b0;
					state_d = S_WAIT_RDY;
				end
			end
			S_WAIT_RDY: begin
				if (!ctrl_q.enable) begin
					state_d = S_IDLE;
				end else if (ready_eff) begin
					st_set[ST_READY] = 1'b1;
					st_set[ST_INT] = ctrl_q.int_on_ready;
					state_d = S_REQ;
				end
			end
			S_REQ: begin
				if (busack_s) begin
					own_d = 1'b1;
					cyc_d = 2'h0;
					state_d = fly_ok ? S_FLY : S_RD;
					if (!first_q) begin
						if (port_q.a_is_src || fly_ok) begin
							cnt_a_d = step_addr(cnt_a_q, port_q.a_step);
						end
						if (!port_q.a_is_src || fly_ok) begin
							cnt_b_d = step_addr(cnt_b_q, port_q.b_step);
						end
					end
				end
			end
			S_RD: begin
				cyc_d = cyc_q + 2'h1;
				if (cyc_end) begin
					data_d = din_s2_q;
					cyc_d = 2'h0;
					if (write_on) begin
						state_d = S_WR;
						if (!first_q) begin
							if (port_q.a_is_src) begin
								cnt_b_d = step_addr(cnt_b_q, port_q.b_step);
							end else begin
								cnt_a_d = step_addr(cnt_a_q, port_q.a_step);
							end
						end
					end else begin
						state_d = S_CHECK;
					end
				end
			end
			S_WR, S_FLY: begin
				cyc_d = cyc_q + 2'h1;
				if (cyc_end) begin
					if (state_q == S_FLY) begin
						data_d = din_s2_q;
					end
					cyc_d = 2'h0;
					state_d = S_CHECK;
				end
			end
			S_CHECK: begin
				first_d = 1'b0;
				count_d = count_q + 16'h0001;
				st_set[ST_MATCH] = search_on & hit;
				st_set[ST_EOB] = eob;
				st_set[ST_INT] = (search_on & hit & ctrl_q.int_on_match) |
					(eob & ctrl_q.int_on_eob);
				if (eob || (search_on && hit && ctrl_q.stop_on_match)) begin
					stop_d = 1'b1;
					hw_stop = 1'b1;
					state_d = S_REL;
				end else if (ctrl_q.mode == MODE_BYTE) begin
					state_d = S_REL;
				end else if (ctrl_q.mode == MODE_CONT) begin
					state_d = S_PAUSE;
				end else if (!ready_eff || (search_on && hit)) begin
					state_d = S_REL;
				end else begin
					state_d = S_PAUSE;
				end
			end
			S_PAUSE: begin
				if (ready_eff) begin
					cyc_d = 2'h0;
					state_d = fly_ok ? S_FLY : S_RD;
					if (port_q.a_is_src || fly_ok) begin
						cnt_a_d = step_addr(cnt_a_q, port_q.a_step);
					end
					if (!port_q.a_is_src || fly_ok) begin
						cnt_b_d = step_addr(cnt_b_q, port_q.b_step);
					end
				end
			end
			S_REL: begin
				own_d = 1'b0;
				if (!busack_s) begin
					state_d = stop_q ? S_IDLE : S_WAIT_RDY;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Bus drive, derived from the next state
	always_comb begin
		bus_d.addr = 16'h0000;
		bus_d.dout = data_d;
		bus_d.mreq_n = 1'b1;
		bus_d.iorq_n = 1'b1;
		bus_d.rd_n = 1'b1;
		bus_d.wr_n = 1'b1;
		if (state_d == S_RD) begin
			bus_d.addr = port_q.a_is_src ? cnt_a_d : cnt_b_d;
			bus_d.rd_n = 1'b0;
			if ((port_q.a_is_src ? port_q.a_is_io : port_q.b_is_io)) begin
				bus_d.iorq_n = 1'b0;
			end else begin
				bus_d.mreq_n = 1'b0;
			end
		end else if (state_d == S_WR) begin
			bus_d.addr = port_q.a_is_src ? cnt_b_d : cnt_a_d;
			bus_d.wr_n = 1'b0;
			if ((port_q.a_is_src ? port_q.b_is_io : port_q.a_is_io)) begin
				bus_d.iorq_n = 1'b0;
			end else begin
				bus_d.mreq_n = 1'b0;
			end
		end else if (state_d == S_FLY) begin
			bus_d.addr = port_q.a_is_io ? cnt_b_d : cnt_a_d;
			bus_d.mreq_n = 1'b0;
			bus_d.iorq_n = 1'b0;
			bus_d.rd_n = 1'b0;
			bus_d.wr_n = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			cyc_q <= 2'h0;
			cnt_a_q <= 16'h0000;
			cnt_b_q <= 16'h0000;
			count_q <= 16'h0000;
			data_q <= 8'h00;
			first_q <= 1'b1;
			stop_q <= 1'b0;
			own_q <= 1'b0;
			bus_q <= '1;
		end else begin
			state_q <= state_d;
			cyc_q <= cyc_d;
			cnt_a_q <= cnt_a_d;
			cnt_b_q <= cnt_b_d;
			count_q <= count_d;
			data_q <= data_d;
			first_q <= first_d;
			stop_q <= stop_d;
			own_q <= own_d;
			bus_q <= bus_d;
		end
	end

	assign bus_req = (state_q == S_REQ) || (own_q && (state_q != S_REL));
	assign sys_out = bus_q;
	assign sys_oe = own_q & busack_s;
	assign sys_data_oe = own_q & busack_s & (state_q == S_WR);
	assign int_req = status_q[ST_INT];

	// ==========================================================
	// Register file and AXI4-Lite slave
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign do_wr = aw_have_q && w_have_q;

	always_comb begin
		rd_err = 1'b0;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == OFS_CTRL) begin
			rd_word = {16'h0000, ctrl_q};
		end else if (s_axi_araddr == OFS_PORT) begin
			rd_word = {24'h000000, port_q};
		end else if (s_axi_araddr == OFS_START_A) begin
			rd_word = {16'h0000, start_a_q};
		end else if (s_axi_araddr == OFS_START_B) begin
			rd_word = {16'h0000, start_b_q};
		end else if (s_axi_araddr == OFS_BLOCK_LEN) begin
			rd_word = {16'h0000, len_q};
		end else if (s_axi_araddr == OFS_MATCH) begin
			rd_word = {16'h0000, mask_q, match_q};
		end else if (s_axi_araddr == OFS_STATUS) begin
			rd_word = {26'h0000000, ready_eff, (state_q != S_IDLE), status_q};
		end else if (s_axi_araddr == OFS_COUNT) begin
			rd_word = {16'h0000, count_q};
		end else if (s_axi_araddr == OFS_ADDR_A) begin
			rd_word = {16'h0000, cnt_a_q};
		end else if (s_axi_araddr == OFS_ADDR_B) begin
			rd_word = {16'h0000, cnt_b_q};
		end else begin
			rd_err = 1'b1;
		end
	end

	always_comb begin
		aw_have_d = aw_have_q | (s_axi_awvalid & s_axi_awready);
		aw_addr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr_q;
		w_have_d = w_have_q | (s_axi_wvalid & s_axi_wready);
		w_data_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data_q;
		w_strb_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb_q;
		bvalid_d = bvalid_q & ~s_axi_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q & ~s_axi_rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		port_d = port_q;
		start_a_d = start_a_q;
		start_b_d = start_b_q;
		len_d = len_q;
		match_d = match_q;
		mask_d = mask_q;
		st_clr = 4'h0;
		wr_err = 1'b0;
		wr_word = 32'h0000_0000;
		if (hw_stop) begin
			ctrl_d.enable = 1'b0;
		end
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			if (aw_addr_q == OFS_CTRL) begin
				wr_word = merge({16'h0000, ctrl_q}, w_data_q, w_strb_q);
				ctrl_d = wr_word[15:0];
				ctrl_d.rsvd = 4'h0;
			end else if (aw_addr_q == OFS_PORT) begin
				wr_word = merge({24'h000000, port_q}, w_data_q, w_strb_q);
				port_d = wr_word[7:0];
				port_d.rsvd = 1'b0;
			end else if (aw_addr_q == OFS_START_A) begin
				wr_word = merge({16'h0000, start_a_q}, w_data_q, w_strb_q);
				start_a_d = wr_word[15:0];
			end else if (aw_addr_q == OFS_START_B) begin
				wr_word = merge({16'h0000, start_b_q}, w_data_q, w_strb_q);
				start_b_d = wr_word[15:0];
			end else if (aw_addr_q == OFS_BLOCK_LEN) begin
				wr_word = merge({16'h0000, len_q}, w_data_q, w_strb_q);
				len_d = wr_word[15:0];
			end else if (aw_addr_q == OFS_MATCH) begin
				wr_word = merge({16'h0000, mask_q, match_q}, w_data_q, w_strb_q);
				match_d = wr_word[7:0];
				mask_d = wr_word[15:8];
			end else if (aw_addr_q == OFS_STATUS) begin
				st_clr = w_strb_q[0] ? w_data_q[3:0] : 4'h0;
			end else if (aw_addr_q != OFS_COUNT && aw_addr_q != OFS_ADDR_A &&
				aw_addr_q != OFS_ADDR_B) begin
				wr_err = 1'b1;
			end
			bresp_d = wr_err ? 2'h2 : 2'h0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_word;
			rresp_d = rd_err ? 2'h2 : 2'h0;
		end
		status_d = (status_q & ~st_clr) | st_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
			ctrl_q <= CTRL_RST;
			port_q <= PORT_RST;
			start_a_q <= 16'h0000;
			start_b_q <= 16'h0000;
			len_q <= LEN_RST;
			match_q <= MATCH_RST;
			mask_q <= MASK_RST;
			status_q <= 4'h0;
		end else begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q <= w_have_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
			port_q <= port_d;
			start_a_q <= start_a_d;
			start_b_q <= start_b_d;
			len_q <= len_d;
			match_q <= match_d;
			mask_q <= mask_d;
			status_q <= status_d;
		end
	end

endmodule : dma_class_mode_sequencer

// >>> hdl/dma_seq_pkg.sv
// Package for the single-channel byte DMA sequencer.
// Assumes one 50 MHz clock and AXI4-Lite register access with 32-bit data.
package dma_seq_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_NS = 20;
	localparam int BUS_CYCLE_NS = 80;
	localparam int CYC_CLKS = (BUS_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] CYC_LAST = 2'(CYC_CLKS - 1);

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORT = 8'h04;
	localparam logic [7:0] OFS_START_A = 8'h08;
	localparam logic [7:0] OFS_START_B = 8'h0c;
	localparam logic [7:0] OFS_BLOCK_LEN = 8'h10;
	localparam logic [7:0] OFS_MATCH = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_COUNT = 8'h1c;
	localparam logic [7:0] OFS_ADDR_A = 8'h20;
	localparam logic [7:0] OFS_ADDR_B = 8'h24;

	// ==========================================================
	// Field positions of the status register
	localparam int ST_MATCH = 0;
	localparam int ST_EOB = 1;
	localparam int ST_READY = 2;
	localparam int ST_INT = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_RDY_NOW = 5;

	// ==========================================================
	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0080;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [15:0] LEN_RST = 16'h0001;
	localparam logic [7:0] MATCH_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;

	// ==========================================================
	// Encodings
	typedef enum logic [1:0] {
		CLS_TRANSFER = 2'h0,
		CLS_SEARCH = 2'h1,
		CLS_XFER_SEARCH = 2'h2,
		CLS_RSVD = 2'h3
	} op_class_t;

	typedef enum logic [1:0] {
		MODE_BYTE = 2'h0,
		MODE_BURST = 2'h1,
		MODE_CONT = 2'h2,
		MODE_RSVD = 2'h3
	} op_mode_t;

	typedef enum logic [1:0] {
		STEP_INC = 2'h0,
		STEP_DEC = 2'h1,
		STEP_FIX = 2'h2,
		STEP_FIX2 = 2'h3
	} step_t;

	typedef struct packed {
		logic [3:0] rsvd;
		logic int_on_ready;
		logic int_on_eob;
		logic int_on_match;
		logic stop_on_match;
		logic ready_high;
		logic force_ready;
		op_mode_t mode;
		logic simultaneous;
		op_class_t op_class;
		logic enable;
	} ctrl_t;

	typedef struct packed {
		logic rsvd;
		step_t b_step;
		step_t a_step;
		logic b_is_io;
		logic a_is_io;
		logic a_is_src;
	} port_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dout;
		logic mreq_n;
		logic iorq_n;
		logic rd_n;
		logic wr_n;
	} sysbus_t;

endpackage : dma_seq_pkg

// >>> hdl/dma_match_cmp.sv
// Masked byte comparator for the search classes.
// Assumes all inputs come from registers on the same clock.
module dma_match_cmp (
	// Operands
	input wire logic [7:0] data,
	input wire logic [7:0] match,
	input wire logic [7:0] mask,
	// Result
	output logic hit
);

	// ==========================================================
	// Compare
	always_comb begin
		hit = (((data ^ match) & mask) == 8'h00);
	end

endmodule : dma_match_cmp

// >>> verification/dma_class_mode_sequencer_assertions.sv
// Checker for the system bus side of the byte DMA sequencer.
// Assumes it is bound to the sequencer's ports and sees one clock.
module dma_class_mode_sequencer_assertions
	import dma_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Watched ports
	input wire logic bus_req,
	input wire logic bus_ack,
	input wire sysbus_t sys_out,
	input wire logic sys_oe,
	input wire logic sys_data_oe
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_oe_ack;
		sys_oe |-> bus_ack && (bus_req || $past(bus_req));
	endproperty
	a_oe_ack: assert property (p_oe_ack) else $error("bus driven without grant");
	property p_data_wr;
		sys_data_oe |-> sys_oe && !sys_out.wr_n && sys_out.rd_n;
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("data driven outside write");
	property p_dout_hold;
		sys_data_oe && $past(sys_data_oe) |-> $stable(sys_out.dout);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("write data moved");
	property p_rd_len;
		$fell(sys_out.rd_n) |-> !sys_out.rd_n [*4] ##1 sys_out.rd_n;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read cycle length wrong");
	property p_wr_len;
		$fell(sys_out.wr_n) |-> !sys_out.wr_n [*4] ##1 sys_out.wr_n;
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("write cycle length wrong");
	property p_rd_first;
		$fell(sys_out.wr_n) && sys_out.rd_n |-> !$past(sys_out.rd_n);
	endproperty
	a_rd_first: assert property (p_rd_first) else $error("write not after read");
	property p_release;
		$fell(bus_req) |-> ##1 !sys_oe [*4];
	endproperty
	a_release: assert property (p_release) else $error("bus taken back at once");
	property p_strobe_own;
		!(sys_out.rd_n && sys_out.wr_n) |-> sys_oe;
	endproperty
	a_strobe_own: assert property (p_strobe_own) else $error("strobe without bus");
	property p_fly;
		!sys_out.rd_n && !sys_out.wr_n |-> !sys_out.mreq_n && !sys_out.iorq_n;
	endproperty
	a_fly: assert property (p_fly) else $error("flyby not memory with io");
	property p_grant;
		$rose(sys_oe) |-> $past(bus_req, 3) && $past(bus_ack, 2);
	endproperty
	a_grant: assert property (p_grant) else $error("bus taken before grant");
endmodule : dma_class_mode_sequencer_assertions

bind dma_class_mode_sequencer dma_class_mode_sequencer_assertions u_chk (.*);

// >>> verification/host_bus_model.sv
// Host processor and port memory on the far side of the system bus.
// Assumes the sequencer drives the bus only while it holds the grant.
module host_bus_model
	import dma_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Arbitration
	input wire logic bus_req,
	output logic bus_ack,
	// System bus
	input wire sysbus_t sys_out,
	input wire logic sys_oe,
	input wire logic sys_data_oe,
	output logic [7:0] sys_din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem_q [256];
	logic [7:0] wr_q [$];
	logic [7:0] last_q, wb_q;
	logic wr_n_q, rd_n_q;
	int wait_q, rd_cnt;
	// ==========================================================
	// Grant after a random delay, take the bus back when request drops
	always @(posedge aclk) begin
		if (!aresetn) begin
			bus_ack <= 0;
			wait_q <= 2;
		end else if (!bus_req) begin
			bus_ack <= 0;
			wait_q <= 1 + $urandom_range(3);
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
		end else begin
			bus_ack <= 1;
		end
	end
	// ==========================================================
	// Ports: read data from memory, record every write
	assign sys_din = (sys_oe && !sys_out.rd_n) ? mem_q[sys_out.addr[7:0]] : ~last_q;
	always @(posedge aclk) begin
		last_q <= sys_din;
		wr_n_q <= sys_out.wr_n | !sys_oe;
		rd_n_q <= sys_out.rd_n | !sys_oe;
		if (rd_n_q && sys_oe && !sys_out.rd_n) rd_cnt <= rd_cnt + 1;
		if (sys_oe && !sys_out.wr_n) begin
			wb_q <= !sys_out.rd_n ? mem_q[sys_out.addr[7:0]] :
				(sys_data_oe ? sys_out.dout : ~sys_out.dout);
			if (sys_out.rd_n && !sys_out.mreq_n)
				mem_q[sys_out.addr[7:0]] <= sys_data_oe ? sys_out.dout : ~sys_out.dout;
		end
		if (!wr_n_q && (sys_out.wr_n || !sys_oe)) wr_q.push_back(wb_q);
	end
endmodule : host_bus_model

// >>> verification/dma_class_mode_sequencer_tb.sv
// Self-checking bench for the byte DMA sequencer.
// Assumes the host bus model and the bound checker.
module dma_class_mode_sequencer_tb;
	import dma_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, sys_din;
	logic [7:0] m [256];
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic bus_req, bus_ack, port_ready, int_req, sys_oe, sys_data_oe, int_at_req;
	sysbus_t sys_out;
	logic [7:0] exp_q [$];
	int fails, tests_run, reqs, rels, k;
	dma_class_mode_sequencer dut (.*);
	host_bus_model u_host (.*);
	initial begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if ($rose(bus_req)) reqs++;
		if ($rose(bus_req)) int_at_req = int_req;
		if ($fell(bus_req)) rels++;
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic results();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : axr
	task automatic run(input logic [15:0] c, input logic [7:0] p, sa, da, len, mt, mk);
		logic [31:0] d;
		logic [1:0] r;
		logic hit;
		int j, lim;
		exp_q = {};
		hit = 0;
		lim = (len == 0) ? 1 : len;
		for (j = 0; j <= lim && !(hit && c[8]); j++) begin
			d = m[8'(sa + j)];
			if (c[2:1] != 2'h0 && ((d[7:0] ^ mt) & mk) == 8'h00) hit = 1;
			if (c[2:1] != 2'h1) exp_q.push_back(d[7:0]);
			if (c[2:1] != 2'h1 && !p[2]) m[8'(da + j)] = d[7:0];
		end
		u_host.wr_q = {};
		u_host.rd_cnt = 0;
		reqs = 0;
		rels = 0;
		axw(OFS_PORT, p, r);
		axw(OFS_START_A, sa, r);
		axw(OFS_START_B, da, r);
		axw(OFS_BLOCK_LEN, len, r);
		axw(OFS_MATCH, {mk, mt}, r);
		axw(OFS_STATUS, 32'hf, r);
		axw(OFS_CTRL, c, r);
		d = 32'h10;
		for (int n = 0; n < 400 && d[4]; n++) axr(OFS_STATUS, d, r);
		chk("busy", 0, d[4]);
		chk("status", {j == lim + 1, hit}, d[1:0]);
		chk("writes", exp_q.size(), u_host.wr_q.size());
		foreach (exp_q[i]) chk("data", exp_q[i], u_host.wr_q[i]);
		chk("reads", j, u_host.rd_cnt);
		for (int i = 0; i < j && !p[2]; i++) begin
			chk("dest", m[8'(da + i)], u_host.mem_q[8'(da + i)]);
		end
	endtask : run
	task automatic drop_ready();
		repeat (45 + $urandom_range(15)) @(posedge aclk);
		port_ready <= 0;
		repeat (40) @(posedge aclk);
		port_ready <= 1;
	endtask : drop_ready
	// ==========================================================
	// Main sequence
	logic [7:0] ra [5] = '{OFS_CTRL, OFS_PORT, OFS_BLOCK_LEN, OFS_MATCH, 8'h28};
	logic [31:0] rv [5] = '{32'h80, 32'h0, 32'h1, 32'hff00, 32'h0};
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		{aresetn, port_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		k = $urandom(70);
		for (k = 0; k < 256; k++) m[k] = 8'($urandom);
		for (k = 0; k < 256; k++) u_host.mem_q[k] = m[k];
		for (k = 0; k < 5; k++) begin
			axr(ra[k], d, r);
			chk("reset value", rv[k], d);
			chk("rresp", (k == 4) ? 2 : 0, r);
		end
		axw(8'h28, 32'h1, r);
		chk("bresp", 2, r);
		axw(OFS_COUNT, 32'h5, r);
		axr(OFS_COUNT, d, r);
		chk("count ro", 0, d);
		run(16'h00c9, 8'h01, 8'h10, 8'h80, 8'h03, 8'h00, 8'hff);
		chk("requests", 4, reqs);
		port_ready <= 1;
		fork
			run(16'h0895, 8'h45, 8'h20, 8'h05, 8'h05, 8'h5a, 8'hff);
			drop_ready();
		join
		chk("burst release", 1, rels >= 2);
		chk("int before req", 1, int_at_req);
		fork
			run(16'h00a1, 8'h45, 8'h30, 8'h05, 8'h05, 8'h00, 8'hff);
			drop_ready();
		join
		chk("cont release", 1, rels);
		port_ready <= 0;
		m[8'h43] = 8'ha5;
		u_host.mem_q[8'h43] = 8'ha5;
		run(16'h01e3, 8'h01, 8'h40, 8'h00, 8'h07, 8'ha0, 8'hf0);
		run(16'h00d9, 8'h45, 8'h60, 8'h05, 8'h00, 8'h00, 8'hff);
		results();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		fails++;
		results();
	end
endmodule : dma_class_mode_sequencer_tb
